//--- wvm_pkg.sv
// Shared constants and types of the wide vector and opmask register file
package wvm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Geometry
  localparam int unsigned VL_BITS      = 512;  // Widest vector view
  localparam int unsigned NUM_VREG     = 32;   // Vector registers, 64-bit mode
  localparam int unsigned NUM_VREG32   = 8;    // Vector registers, 32-bit mode
  localparam int unsigned NUM_KREG     = 8;    // Opmask registers
  localparam int unsigned MASK_W_MAX   = 64;   // mask_width_max
  localparam int unsigned ELEM_W       = 32;   // Element width
  localparam int unsigned LANES        = 16;   // Elements per 512-bit vector

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_XCR       = 8'h04;
  localparam logic [7:0] OFS_CMD       = 8'h08;
  localparam logic [7:0] OFS_STATUS    = 8'h0c;
  localparam logic [7:0] OFS_SEL       = 8'h10;
  localparam logic [7:0] OFS_DATA      = 8'h14;
  localparam logic [7:0] OFS_MASK_LO   = 8'h18;
  localparam logic [7:0] OFS_MASK_HI   = 8'h1c;
  localparam logic [7:0] OFS_IDENT     = 8'h20;
  localparam logic [7:0] OFS_DISP      = 8'h24;
  localparam logic [7:0] OFS_GPR_LO    = 8'h28;
  localparam logic [7:0] OFS_GPR_HI    = 8'h2c;

  ////////////////////////////////////////////////////////////////////////////
  // Command field positions
  localparam int unsigned CMD_OP_LSB   = 0;   // 3 bits
  localparam int unsigned CMD_DST_LSB  = 3;   // 5 bits
  localparam int unsigned CMD_SRC1_LSB = 8;   // 5 bits, prefix-encoded source
  localparam int unsigned CMD_SRC2_LSB = 13;  // 5 bits
  localparam int unsigned CMD_MASK_LSB = 18;  // 3 bits
  localparam int unsigned CMD_ZERO_BIT = 21;  // zeroing_select_bit
  localparam int unsigned CMD_VL_LSB   = 22;  // 2 bits
  localparam int unsigned CMD_RC_BIT   = 24;  // Explicit rounding control
  localparam int unsigned CMD_MAP_LSB  = 25;  // 2 bits, compacted escape
  localparam int unsigned CMD_PP_LSB   = 27;  // 2 bits, compacted prefix
  localparam int unsigned CMD_LEG_BIT  = 29;  // Legacy register class

  // Window select, status, control and identification fields
  localparam int unsigned SEL_REG_LSB  = 0;   // 5 bits
  localparam int unsigned SEL_WORD_LSB = 5;   // 4 bits
  localparam int unsigned SEL_KREG_LSB = 9;   // 3 bits
  localparam int unsigned ST_BUSY_BIT  = 0;
  localparam int unsigned ST_UD_BIT    = 1;
  localparam int unsigned CTRL_M64_BIT = 0;
  localparam int unsigned XCR_VEC_LSB  = 1;   // Bits 2:1
  localparam int unsigned IDENT_FF_BIT = 16;  // foundation_feature_flag

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and the vector-state enable value
  localparam logic       CTRL_M64_RST  = 1'b1;
  localparam logic [7:0] XCR_RST       = 8'h00;
  localparam logic [1:0] XCR_VEC_OK    = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Encodings
  localparam logic [2:0] OP_MOV   = 3'h0;
  localparam logic [2:0] OP_ADD   = 3'h1;
  localparam logic [2:0] OP_AND   = 3'h2;
  localparam logic [2:0] OP_BCAST = 3'h3;
  localparam logic [2:0] OP_KMOV  = 3'h4;
  localparam logic [2:0] OP_KAND  = 3'h5;
  localparam logic [1:0] VL_128   = 2'h0;
  localparam logic [1:0] VL_256   = 2'h1;
  localparam logic [1:0] VL_512   = 2'h2;
  localparam logic [1:0] PP_MASK  = 2'h0;
  localparam logic [1:0] PP_VEC   = 2'h1;
  localparam logic [1:0] MAP_NONE = 2'h0;
  localparam logic [4:0] LANES_128 = 5'h04;
  localparam logic [4:0] LANES_256 = 5'h08;
  localparam logic [4:0] LANES_512 = 5'h10;
  localparam logic [3:0] SH_ELEM  = 4'h2;  // Displacement scale, broadcast
  localparam logic [3:0] SH_128   = 4'h4;
  localparam logic [3:0] SH_256   = 4'h5;
  localparam logic [3:0] SH_512   = 4'h6;

  // Command engine states
  typedef enum logic [0:0] {WVM_IDLE, WVM_EXEC} wvm_exec_t;

endpackage

//--- wvm_lane_if.sv
// Bundle between the command engine and the element lane unit
`timescale 1ns/1ps
interface wvm_lane_if;
  import wvm_pkg::*;
  logic [VL_BITS-1:0] src1;     // First source vector
  logic [VL_BITS-1:0] src2;     // Second source vector
  logic [VL_BITS-1:0] old_dst;  // Destination before the operation
  logic [VL_BITS-1:0] result;   // New destination value
  logic [ELEM_W-1:0]  bcast;    // Broadcast element
  logic [LANES-1:0]   kmask;    // Effective element mask
  logic               zero;     // Zeroing instead of merging
  logic [2:0]         op;       // Operation
  logic [1:0]         vl;       // Vector length
  modport exec (input src1, src2, old_dst, bcast, kmask, zero, op, vl, output result);
  modport ctrl (output src1, src2, old_dst, bcast, kmask, zero, op, vl, input result);
endinterface // wvm_lane_if

//--- wvm_lane_unit.sv
// Per-element operation, predication and upper zeroing
`timescale 1ns/1ps
module wvm_lane_unit import wvm_pkg::*; (
  // Operands and result
  wvm_lane_if.exec lif
);

  logic [4:0] nlanes;  // Lanes inside the vector length

  // Lane count from the vector length
  always_comb begin
    unique case (lif.vl)
      VL_128:  nlanes = LANES_128;
      VL_256:  nlanes = LANES_256;
      default: nlanes = LANES_512;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // One slice per element
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    logic [ELEM_W-1:0] a;  // First source element
    logic [ELEM_W-1:0] b;  // Second source element
    logic [ELEM_W-1:0] r;  // Computed element
    logic [ELEM_W-1:0] d;  // Old destination element
    logic              in_vl;
    assign a = lif.src1[g*ELEM_W +: ELEM_W];
    assign b = lif.src2[g*ELEM_W +: ELEM_W];
    assign d = lif.old_dst[g*ELEM_W +: ELEM_W];
    assign in_vl = (5'(g) < nlanes);

    // Element operation
    always_comb begin
      unique case (lif.op)
        OP_ADD:   r = a + b;
        OP_AND:   r = a & b;
        OP_BCAST: r = lif.bcast;  // Same element in every position [RULE_08]
        default:  r = a;
      endcase
    end

    // Masked-off elements merge or clear; lanes past the length clear
    always_comb begin
      if (!in_vl) begin
        lif.result[g*ELEM_W +: ELEM_W] = '0;  // [RULE_07]
      end else if (lif.kmask[g]) begin
        lif.result[g*ELEM_W +: ELEM_W] = r;   // [RULE_04]
      end else if (lif.zero) begin
        lif.result[g*ELEM_W +: ELEM_W] = '0;  // [RULE_06]
      end else begin
        lif.result[g*ELEM_W +: ELEM_W] = d;   // [RULE_06]
      end
    end
  end

endmodule // wvm_lane_unit

//--- wvm_regfile_top.sv
// Wide vector and opmask register file with command engine, APB slave
//
// Operation
// RULE_01: 512-bit registers; low 256/128 bits alias narrower views
// RULE_02: 32 vector registers in 64-bit, 8 in 32-bit
// RULE_03: Eight opmask registers, each 64 bits wide
// RULE_04: Masks 1-7 predicate; mask zero means all elements
// RULE_05: Zeroing-select bit chooses merging or zeroing
// RULE_06: Zeroing clears masked-off elements, merging keeps them
// RULE_07: Narrow operations zero destination bits above their length
// RULE_08: Broadcast one element; conditional element access
// RULE_09: Explicit rounding control only at full length
// RULE_10: Prefix carries opcode extension and compacted escape
// RULE_11: Prefix encodes one source; 32 registers addressable
// RULE_12: Compressed displacement scaled by operand size
// RULE_13: Relaxed alignment: no alignment checking here
// RULE_14: Legacy register classes reject the extended prefix
// RULE_15: Mask operations use only masks or general register
// RULE_16: Identification result bit 16 reports foundation support
// RULE_17: Software checks state flags before use
// RULE_18: Vector state disabled in control register faults
//
// Each transfer gets one wait state.
`timescale 1ns/1ps
module wvm_regfile_top import wvm_pkg::*; (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    // Architectural registers
    logic [NUM_VREG-1:0][VL_BITS-1:0]    vreg;    // Vector registers
    logic [NUM_KREG-1:0][MASK_W_MAX-1:0] kreg;    // Opmask registers

    // Control and command
    logic                                mode64;  // 64-bit operating mode
    logic [7:0]                          xcr;     // extended_control_reg
    logic [31:0]                         cmd;     // Last command
    logic [31:0]                         sel;     // Window select
    logic [31:0]                         gpr_lo;  // General register, low
    logic [31:0]                         gpr_hi;  // General register, high
    logic [7:0]                          disp8;   // Raw displacement

    // Engine and bus
    logic                                ud;      // Sticky fault flag
    wvm_exec_t                           st;      // Engine state
    logic                                pready;  // Bus answer
    logic                                pslverr; // Bus error
    logic [31:0]                         prdata;  // Bus read data
  } wvm_top_state_t;

  wvm_top_state_t s_q;  // Registered state
  wvm_top_state_t s_d;  // Next state

  wvm_lane_if lif ();   // Lane unit bundle

  ////////////////////////////////////////////////////////////////////////////
  // Command fields
  // Opcode and registers
  logic [2:0]  c_op;
  logic [4:0]  c_dst;
  logic [4:0]  c_src1;
  logic [4:0]  c_src2;

  // Mask select
  logic [2:0]  c_mask;

  // Length
  logic [1:0]  c_vl;

  // Prefix fields
  logic [1:0]  c_map;
  logic [1:0]  c_pp;

  // Flags
  logic        c_zero;
  logic        c_rc;
  logic        c_leg;
  logic        c_kop;   // Mask-manipulation operation

  // Slices of the command
  assign c_op   = s_q.cmd[CMD_OP_LSB +: 3];
  assign c_dst  = s_q.cmd[CMD_DST_LSB +: 5];
  assign c_src1 = s_q.cmd[CMD_SRC1_LSB +: 5];  // Prefix-carried operand [RULE_11]
  assign c_src2 = s_q.cmd[CMD_SRC2_LSB +: 5];
  assign c_mask = s_q.cmd[CMD_MASK_LSB +: 3];
  assign c_zero = s_q.cmd[CMD_ZERO_BIT];       // Predication style [RULE_05]
  assign c_vl   = s_q.cmd[CMD_VL_LSB +: 2];
  assign c_rc   = s_q.cmd[CMD_RC_BIT];
  assign c_map  = s_q.cmd[CMD_MAP_LSB +: 2];
  assign c_pp   = s_q.cmd[CMD_PP_LSB +: 2];
  assign c_leg  = s_q.cmd[CMD_LEG_BIT];

  // Opmask-only operations
  assign c_kop  = (c_op == OP_KMOV) || (c_op == OP_KAND);

  // Window select fields
  logic [4:0]  w_reg;
  logic [3:0]  w_word;
  logic [2:0]  w_kreg;
  logic        w_ok;    // Window register exists in this mode

  // Slices of the select
  assign w_reg  = s_q.sel[SEL_REG_LSB +: 5];
  assign w_word = s_q.sel[SEL_WORD_LSB +: 4];
  assign w_kreg = s_q.sel[SEL_KREG_LSB +: 3];
  assign w_ok   = s_q.mode64 || (w_reg < 5'(NUM_VREG32));  // [RULE_02]

  ////////////////////////////////////////////////////////////////////////////
  // Lane unit hookup
  logic [MASK_W_MAX-1:0] kval;  // Selected opmask value

  // Mask zero selects unconditional processing
  always_comb begin
    if (c_mask == 3'h0) begin
      kval = '1;                 // [RULE_04]
    end else begin
      kval = s_q.kreg[c_mask];   // [RULE_04]
    end
  end

  // Operands
  assign lif.src1    = s_q.vreg[c_src1];
  assign lif.src2    = s_q.vreg[c_src2];
  assign lif.old_dst = s_q.vreg[c_dst];
  assign lif.bcast   = s_q.gpr_lo;
  assign lif.kmask   = kval[LANES-1:0];

  // Controls
  assign lif.zero    = c_zero;
  assign lif.op      = c_op;
  assign lif.vl      = c_vl;

  // Element lanes
  wvm_lane_unit u_lane (
    .lif (lif)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Fault decode for the pending command
  logic fault;
  logic f_state;  // Vector state disabled
  logic f_enc;    // Illegal encoding
  logic f_reg;    // Register not present in this mode
  logic f_rc;     // Rounding control at a narrow length

  // Classify the command
  always_comb begin
    // State enable
    f_state = (s_q.xcr[XCR_VEC_LSB +: 2] != XCR_VEC_OK);          // [RULE_18]

    // Encoding
    f_enc   = c_leg                                              // [RULE_14]
            || (c_map == MAP_NONE)                               // [RULE_10]
            || (c_kop ? (c_pp != PP_MASK) : (c_pp != PP_VEC))   // [RULE_10]
            || (c_op > OP_KAND)
            || (!c_kop && (c_vl > VL_512));

    // Register count
    f_reg   = !s_q.mode64 && ((c_dst >= 5'(NUM_VREG32))
            || (c_src1 >= 5'(NUM_VREG32))
            || (c_src2 >= 5'(NUM_VREG32)));                      // [RULE_02]

    // Rounding
    f_rc    = !c_kop && c_rc && (c_vl != VL_512);               // [RULE_09]

    // Any of them
    fault   = f_state || f_enc || f_reg || f_rc;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compressed displacement, scaled by the memory operand size
  logic [3:0]  d_sh;
  logic [31:0] disp_scaled;

  // Scale from the size
  always_comb begin
    if (c_op == OP_BCAST) begin
      d_sh = SH_ELEM;            // One element is fetched [RULE_12]
    end else begin
      unique case (c_vl)
        VL_128:  d_sh = SH_128;  // [RULE_12]
        VL_256:  d_sh = SH_256;
        default: d_sh = SH_512;
      endcase
    end

    // Sign-extend, scale
    disp_scaled = {{24{s_q.disp8[7]}}, s_q.disp8} << d_sh;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read decode
  logic [31:0] rd_data;
  logic        hit;

  // Read multiplexer
  always_comb begin
    rd_data = '0;
    hit     = 1'b1;

    // One word per offset
    unique case (paddr_i)
      OFS_CTRL:    rd_data[CTRL_M64_BIT] = s_q.mode64;
      OFS_XCR:     rd_data[7:0] = s_q.xcr;
      OFS_CMD:     rd_data = s_q.cmd;
      OFS_STATUS: begin
        rd_data[ST_BUSY_BIT] = (s_q.st == WVM_EXEC);
        rd_data[ST_UD_BIT]   = s_q.ud;
      end
      OFS_SEL:     rd_data = s_q.sel;

      OFS_DATA: begin
        // Words 0-3 are the 128-bit view, 0-7 the 256-bit view
        rd_data = s_q.vreg[w_reg][w_word*ELEM_W +: ELEM_W];  // [RULE_01]
        hit     = w_ok;
      end

      OFS_MASK_LO: rd_data = s_q.kreg[w_kreg][31:0];         // [RULE_03]
      OFS_MASK_HI: rd_data = s_q.kreg[w_kreg][63:32];        // [RULE_03]

      OFS_IDENT:   rd_data[IDENT_FF_BIT] = 1'b1;             // [RULE_16]
      OFS_DISP:    rd_data = disp_scaled;
      OFS_GPR_LO:  rd_data = s_q.gpr_lo;
      OFS_GPR_HI:  rd_data = s_q.gpr_hi;
      // Unmapped: error
      default:     hit = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  logic acc;   // Access phase, answer not yet given
  logic fin;   // Transfer completes at this edge

  // Bus, writes, engine
  always_comb begin
    // Hold by default
    s_d = s_q;

    acc = psel_i && penable_i && !s_q.pready;
    fin = psel_i && penable_i && s_q.pready;

    // Bus answer one cycle into the access phase
    s_d.pready = acc;
    if (acc) begin
      s_d.pslverr = !hit;
      s_d.prdata  = pwrite_i ? 32'h0000_0000 : rd_data;
    end

    // Register writes take effect at the completing edge
    if (fin && pwrite_i && hit) begin
      unique case (paddr_i)
        OFS_CTRL:   s_d.mode64 = pwdata_i[CTRL_M64_BIT];
        OFS_XCR:    s_d.xcr = pwdata_i[7:0];
        OFS_CMD: begin
          // Start the engine
          s_d.cmd = pwdata_i;
          s_d.st  = WVM_EXEC;
        end
        OFS_STATUS: begin
          // Write one to clear the fault flag
          if (pwdata_i[ST_UD_BIT]) begin
            s_d.ud = 1'b0;
          end
        end
        OFS_SEL:    s_d.sel = pwdata_i;

        OFS_DATA: begin
          s_d.vreg[w_reg][w_word*ELEM_W +: ELEM_W] = pwdata_i;  // [RULE_01]
        end

        OFS_MASK_LO: s_d.kreg[w_kreg][31:0]  = pwdata_i;
        OFS_MASK_HI: s_d.kreg[w_kreg][63:32] = pwdata_i;

        OFS_DISP:   s_d.disp8 = pwdata_i[7:0];
        OFS_GPR_LO: s_d.gpr_lo = pwdata_i;
        OFS_GPR_HI: s_d.gpr_hi = pwdata_i;
        default: begin
          // Read-only identification word ignores writes
        end
      endcase
    end

    // Command engine, one execute cycle per command
    unique case (s_q.st)
      WVM_IDLE: begin
        // Waiting for a command write
      end
      WVM_EXEC: begin
        // One cycle only
        s_d.st = WVM_IDLE;

        if (fault) begin
          s_d.ud = 1'b1;  // Set wins over a clear [RULE_18]
        end else if (c_op == OP_KMOV) begin
          // Mask from the general register only [RULE_15]
          s_d.kreg[c_dst[2:0]] = {s_q.gpr_hi, s_q.gpr_lo};
        end else if (c_op == OP_KAND) begin
          // Masks combine only with masks [RULE_15]
          s_d.kreg[c_dst[2:0]] = s_q.kreg[c_src1[2:0]] & s_q.kreg[c_src2[2:0]];
        end else begin
          // Masked and length-trimmed result; no alignment check [RULE_13]
          s_d.vreg[c_dst] = lif.result;  // [RULE_07]
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      // Constants only
      s_q         <= '0;
      s_q.mode64  <= CTRL_M64_RST;
      s_q.xcr     <= XCR_RST;
      s_q.st      <= WVM_IDLE;
    end else begin
      // Next state
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state register
  assign prdata_o  = s_q.prdata;
  assign pready_o  = s_q.pready;
  assign pslverr_o = s_q.pslverr;

endmodule // wvm_regfile_top

//--- wvm_regfile_props.sv
// Port-level checker of the wide vector and opmask register file
`timescale 1ns/1ps
module wvm_regfile_props import wvm_pkg::*; (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // APB side
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [31:0] prdata_o,
  input  wire logic        pready_o,
  input  wire logic        pslverr_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////
  // Shadows of mode, window index and control register
  logic       m64_q;  // Mode shadow
  logic [4:0] vsel_q; // Window vector index shadow
  logic [7:0] xcr_q;  // Control register shadow
  logic       wdone;  // Write completes at this edge
  logic       rdone;  // Read completes at this edge
  assign wdone = pready_o && psel_i && penable_i && pwrite_i;
  assign rdone = pready_o && psel_i && penable_i && !pwrite_i;
  // Follow completed writes only, as the slave does
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      m64_q  <= CTRL_M64_RST;
      vsel_q <= 5'h00;
      xcr_q  <= XCR_RST;
    end else if (wdone) begin
      if (paddr_i == OFS_CTRL) m64_q <= pwdata_i[CTRL_M64_BIT];
      if (paddr_i == OFS_SEL) vsel_q <= pwdata_i[4:0];
      if (paddr_i == OFS_XCR) xcr_q <= pwdata_i[7:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Handshake
  property p_ready_wait;
    psel_i && penable_i && !pready_o |=> pready_o;
  endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("pready late");
  property p_ready_pulse;
    pready_o |=> !pready_o;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready not a pulse");
  property p_ready_qual;
    pready_o |-> psel_i && penable_i;
  endproperty
  a_ready_qual: assert property (p_ready_qual) else $error("pready outside access");
  property p_unmapped;
    pready_o && (paddr_i > OFS_GPR_HI || paddr_i[1:0] != 2'h0) |-> pslverr_o;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped without error");
  ////////////////////////////////////////////////////////////////////////////
  // Register contents
  property p_ident;
    rdone && paddr_i == OFS_IDENT |-> prdata_o == (32'h1 << IDENT_FF_BIT) && !pslverr_o;
  endproperty
  a_ident: assert property (p_ident) else $error("ident value wrong");
  property p_win_32;
    pready_o && paddr_i == OFS_DATA && !m64_q && vsel_q >= 5'h08 |-> pslverr_o;
  endproperty
  a_win_32: assert property (p_win_32) else $error("high register open in 32-bit mode");
  property p_win_64;
    pready_o && paddr_i == OFS_DATA && m64_q |-> !pslverr_o;
  endproperty
  a_win_64: assert property (p_win_64) else $error("register refused in 64-bit mode");
  property p_xcr_rd;
    rdone && paddr_i == OFS_XCR |-> prdata_o == {24'h000000, xcr_q};
  endproperty
  a_xcr_rd: assert property (p_xcr_rd) else $error("control register readback wrong");
  property p_status_idle;
    rdone && paddr_i == OFS_STATUS |-> !prdata_o[ST_BUSY_BIT] && prdata_o[31:2] == 30'h0;
  endproperty
  a_status_idle: assert property (p_status_idle) else $error("status busy or junk");
endmodule // wvm_regfile_props

bind wvm_regfile_top wvm_regfile_props u_props (.clk_i(clk_i), .rst_i(rst_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o));

//--- tb_top.sv
// Self-checking bench of the wide vector and opmask register file
`timescale 1ns/1ps
module tb_top;
  import wvm_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  // Design ports and bench state
  logic        clk_i, rst_i, psel_i, penable_i, pwrite_i;
  logic [7:0]  paddr_i;
  logic [31:0] pwdata_i, prdata_o;
  logic        pready_o, pslverr_o;
  int          bad_count;     // Mismatches
  int          n_tests;       // Comparisons
  logic [31:0] rd_q;          // Last read data
  logic        err_q;         // Last error response
  int unsigned vm [32][16];   // Vector register model
  logic [63:0] km [8];        // Opmask model
  logic [31:0] glo, ghi;      // General register model
  logic [31:0] bad_cmd [5];   // Commands that must fault
  logic [7:0]  d8;            // Displacement under test
  wvm_regfile_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o));
  ////////////////////////////////////////////////////////////////////////////
  // Compare, bus and model tasks
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One APB transfer; held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    psel_i   <= 1'b1;
    pwrite_i <= w;
    paddr_i  <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 16);
    if (n >= 16) chk("pready", 32'h1, 32'h0);
    rd_q = prdata_o;
    err_q = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd_q);
  endtask
  function automatic logic [31:0] cmd(int op, dst, s1, s2, ms, z, vl, rc, mp, pp, lg);
    return 32'(op) | (32'(dst) << CMD_DST_LSB) | (32'(s1) << CMD_SRC1_LSB)
      | (32'(s2) << CMD_SRC2_LSB) | (32'(ms) << CMD_MASK_LSB) | (32'(z) << CMD_ZERO_BIT)
      | (32'(vl) << CMD_VL_LSB) | (32'(rc) << CMD_RC_BIT) | (32'(mp) << CMD_MAP_LSB)
      | (32'(pp) << CMD_PP_LSB) | (32'(lg) << CMD_LEG_BIT);
  endfunction
  // Launch a legal command and update the model
  task automatic run(input int op, dst, s1, s2, ms, z, vl);
    int unsigned t [16];
    logic [63:0] k;
    wr(OFS_CMD, cmd(op, dst, s1, s2, ms, z, vl, vl == 2, 1, (op >= 4) ? 0 : 1, 0));
    k = (ms == 0) ? '1 : km[ms];
    if (op == 4) km[dst] = {ghi, glo};
    else if (op == 5) km[dst] = km[s1] & km[s2];
    else begin
      for (int i = 0; i < 16; i++) begin
        t[i] = (op == 0) ? vm[s1][i] : (op == 1) ? vm[s1][i] + vm[s2][i]
          : (op == 2) ? (vm[s1][i] & vm[s2][i]) : glo;
        if (i >= (4 << vl)) t[i] = 0;
        else if (!k[i]) t[i] = z ? 0 : vm[dst][i];
      end
      vm[dst] = t;
    end
  endtask
  task automatic vload(input int r);
    for (int w = 0; w < 16; w++) begin
      vm[r][w] = $urandom;
      wr(OFS_SEL, 32'(r) | (32'(w) << SEL_WORD_LSB));
      wr(OFS_DATA, vm[r][w]);
    end
  endtask
  task automatic vchk(input int r);
    for (int w = 0; w < 16; w++) begin
      wr(OFS_SEL, 32'(r) | (32'(w) << SEL_WORD_LSB));
      rd(OFS_DATA, vm[r][w], "vector word");
    end
  endtask
  task automatic fault_clear(input string nm);
    rd(OFS_STATUS, 32'h2, nm);
    wr(OFS_STATUS, 32'h2);
  endtask
  task automatic conclude();
    $display("Counts: %0d compared, %0d mismatched", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Clock and watchdog
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    chk("watchdog", 32'h1, 32'h0);
    conclude();
  end
  ////////////////////////////////////////////////////////////////////////////
  // Tests
  initial begin
    {rst_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = {1'b1, 43'h0};
    {bad_count, n_tests} = 0;
    foreach (vm[i, j]) vm[i][j] = 0;
    foreach (km[i]) km[i] = '0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    void'($urandom(50393));
    rd(OFS_CTRL, 32'h1, "ctrl reset");
    rd(OFS_XCR, 32'h0, "xcr reset");
    wr(OFS_IDENT, 32'hffffffff);
    rd(OFS_IDENT, 32'h00010000, "ident");
    apb(1'b0, 8'h30, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err_q});
    $display("Test reset done");
    wr(OFS_XCR, 32'he6);
    rd(OFS_XCR, 32'he6, "xcr enabled");
    for (int k = 1; k < 3; k++) begin
      {ghi, glo} = {$urandom, $urandom};
      wr(OFS_GPR_LO, glo);
      wr(OFS_GPR_HI, ghi);
      run(4, k, 0, 0, 0, 0, 0);
    end
    run(5, 3, 1, 2, 0, 0, 0);
    for (int k = 1; k < 4; k++) begin
      wr(OFS_SEL, 32'(k) << SEL_KREG_LSB);
      rd(OFS_MASK_LO, km[k][31:0], "mask lo");
      rd(OFS_MASK_HI, km[k][63:32], "mask hi");
    end
    $display("Test opmask done");
    foreach (bad_cmd[i]) vload(i == 0 ? 31 : i + 1);
    for (int i = 0; i < 6; i++) begin
      run(i % 4, 4, 31, 3, (i + 1) % 4, i % 2, i % 3);
      rd(OFS_STATUS, 32'h0, "status ok");
      vchk(4);
    end
    $display("Test vector ops done");
    bad_cmd = '{cmd(1, 4, 2, 3, 0, 0, 2, 0, 1, 1, 1), cmd(1, 4, 2, 3, 0, 0, 2, 0, 0, 1, 0),
      cmd(1, 4, 2, 3, 0, 0, 1, 1, 1, 1, 0), cmd(1, 4, 2, 3, 0, 0, 2, 0, 1, 0, 0),
      cmd(6, 4, 2, 3, 0, 0, 2, 0, 1, 1, 0)};
    foreach (bad_cmd[i]) begin
      wr(OFS_CMD, bad_cmd[i]);
      fault_clear("fault flag");
    end
    wr(OFS_XCR, 32'he0);
    wr(OFS_CMD, cmd(1, 4, 2, 3, 0, 0, 2, 0, 1, 1, 0));
    fault_clear("state off fault");
    wr(OFS_XCR, 32'he6);
    vchk(4);
    $display("Test faults done");
    wr(OFS_CTRL, 32'h0);
    wr(OFS_SEL, 32'h9);
    apb(1'b0, OFS_DATA, 32'h0);
    chk("window err", 32'h1, {31'h0, err_q});
    wr(OFS_CMD, cmd(0, 9, 2, 3, 0, 0, 2, 0, 1, 1, 0));
    fault_clear("mode fault");
    wr(OFS_CTRL, 32'h1);
    $display("Test 32-bit mode done");
    for (int i = 0; i < 4; i++) begin
      d8 = (i == 0) ? 8'h80 : 8'($urandom);
      wr(OFS_CMD, cmd(i == 3 ? 3 : 1, 4, 2, 3, 0, 0, i % 3, 0, 1, 1, 1));
      wr(OFS_DISP, {24'h0, d8});
      rd(OFS_DISP, 32'($signed(d8)) << (i == 3 ? 2 : 4 + i % 3), "disp");
      wr(OFS_STATUS, 32'h2);
    end
    $display("Test displacement done");
    conclude();
  end
endmodule // tb_top
